// ### rx_pkg.sv
// Shared constants, register map and carrier types for the receive back end
package rx_pkg;

  // Clock and reference frequencies
  localparam longint unsigned FDIG_HZ = 64'd26000000;
  localparam longint unsigned FXO_HZ = 64'd26000000;
  localparam longint unsigned FILTER_REF_HZ = 64'd26000000;
  localparam int unsigned CLK_PERIOD_PS = 4000;

  // Intermediate frequency formula terms
  localparam longint unsigned IF_DIV = 64'd12;
  localparam longint unsigned IF_OFFSET_ADD = 64'd100;
  localparam int unsigned IF_SHIFT = 11;

  // Raw GPIO strobe: least high time of the data clock
  localparam int unsigned STROBE_HIGH_NS = 40;
  localparam int unsigned STROBE_HIGH_CYC =
    (STROBE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_GAIN = 8'h04;
  localparam logic [7:0] OFS_FILT_IF = 8'h08;
  localparam logic [7:0] OFS_TMO_CFG = 8'h0C;
  localparam logic [7:0] OFS_TMO_PERIOD = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_FILT_BW = 8'h18;
  localparam logic [7:0] OFS_IF_FREQ = 8'h1C;

  // Field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_ABORT_BIT = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_ALGO_BIT = 4;
  localparam int FILT_E_LSB = 0;
  localparam int FILT_M_LSB = 4;
  localparam int IF_ANA_LSB = 8;
  localparam int IF_DIG_LSB = 16;
  localparam int TMO_ANDOR_BIT = 3;
  localparam int STAT_RX_BIT = 0;
  localparam int STAT_HALT_BIT = 1;
  localparam int STAT_TMO_BIT = 2;
  localparam int STAT_SYNC_BIT = 3;
  localparam int STAT_PGAIN_LSB = 4;

  // Reset values
  localparam logic [11:0] GAIN_RST = 12'h000;
  localparam logic [3:0] FILT_E_RST = 4'h0;
  localparam logic [3:0] FILT_M_RST = 4'h0;
  localparam logic [7:0] IF_ANA_RST = 8'h00;
  localparam logic [7:0] IF_DIG_RST = 8'h00;
  localparam logic [2:0] STOP_MASK_RST = 3'h2;
  localparam logic TMO_ANDOR_RST = 1'b0;
  localparam logic [15:0] TMO_PERIOD_RST = 16'h1000;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Double-sided channel filter bandwidth in 0.1 kHz, index mantissa*10+exponent
  localparam int unsigned FILT_M_MAX = 8;
  localparam int unsigned FILT_E_MAX = 9;
  localparam logic [13:0] CHAN_BW_TENTHS [0:89] = '{
    14'd8001, 14'd4509, 14'd2247, 14'd1123, 14'd561,
    14'd280, 14'd140, 14'd70, 14'd35, 14'd18,
    14'd7951, 14'd4259, 14'd2124, 14'd1062, 14'd530,
    14'd265, 14'd133, 14'd66, 14'd33, 14'd17,
    14'd7684, 14'd4032, 14'd2011, 14'd1005, 14'd502,
    14'd251, 14'd126, 14'd63, 14'd31, 14'd16,
    14'd7368, 14'd3808, 14'd1900, 14'd950, 14'd474,
    14'd237, 14'd119, 14'd59, 14'd30, 14'd15,
    14'd7051, 14'd3621, 14'd1807, 14'd903, 14'd451,
    14'd226, 14'd113, 14'd56, 14'd28, 14'd14,
    14'd6709, 14'd3417, 14'd1706, 14'd853, 14'd426,
    14'd213, 14'd106, 14'd53, 14'd27, 14'd13,
    14'd6423, 14'd3254, 14'd1624, 14'd812, 14'd406,
    14'd203, 14'd101, 14'd51, 14'd25, 14'd13,
    14'd5867, 14'd2945, 14'd1471, 14'd735, 14'd367,
    14'd184, 14'd92, 14'd46, 14'd23, 14'd12,
    14'd5414, 14'd2703, 14'd1350, 14'd675, 14'd337,
    14'd169, 14'd84, 14'd42, 14'd21, 14'd11
  };

  // Modes and states
  typedef enum logic [1:0] {MODE_PACKET, MODE_RAW_FIFO, MODE_RAW_GPIO} data_mode_e;
  typedef enum logic {RX_IDLE, RX_ACTIVE} rx_state_e;

  // Timing loop gain set: low bits are the pre-sync pair
  typedef struct packed {
    logic [2:0] timing_integral_gain_post_sync;
    logic [2:0] timing_proportional_gain_post_sync;
    logic [2:0] timing_integral_gain_pre_sync;
    logic [2:0] timing_proportional_gain_pre_sync;
  } timing_gain_s;

  // AXI4-Lite master to slave
  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } axil_req_s;

  // AXI4-Lite slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_s;

  // Raw receive outputs toward the FIFO and GPIO pins
  typedef struct packed {
    logic fifo_push;
    logic [7:0] fifo_data;
    logic gpio_data;
    logic gpio_clk;
  } raw_out_s;

endpackage : rx_pkg

// ### timing_loop.sv
// Symbol timing loop: first or second order, gain set switched at sync
`timescale 1ns/1ps
`default_nettype none
module timing_loop
  import rx_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Control
  input wire logic restart_i,
  input wire logic second_order_i,
  input wire logic sync_seen_i,
  input wire timing_gain_s gain_i,
  // Phase detector
  input wire logic err_valid_i,
  input wire logic signed [15:0] phase_err_i,
  // Corrections
  output logic signed [15:0] phase_step_o,
  output logic signed [15:0] freq_word_o,
  output logic [2:0] active_p_gain_o
);

  typedef struct packed {
    logic signed [15:0] freq;
    logic signed [15:0] step;
  } loop_st_s;

  loop_st_s s_q;
  loop_st_s s_d;
  logic [2:0] p_gain;
  logic [2:0] i_gain;

  // R2 gain set select
  assign p_gain = sync_seen_i ? gain_i.timing_proportional_gain_post_sync
                              : gain_i.timing_proportional_gain_pre_sync;
  assign i_gain = sync_seen_i ? gain_i.timing_integral_gain_post_sync
                              : gain_i.timing_integral_gain_pre_sync;

  // Larger gain code shifts more, so a smaller code gives a faster loop
  always_comb begin
    s_d = s_q;
    s_d.step = 16'sh0000;
    if (restart_i) begin
      s_d.freq = 16'sh0000;
    end else if (err_valid_i) begin
      // R1 frequency and phase
      if (second_order_i) begin
        s_d.freq = s_q.freq + (phase_err_i >>> i_gain);
        s_d.step = (phase_err_i >>> p_gain) + s_q.freq;
      end else begin
        // R21 delay-only correction
        s_d.step = phase_err_i >>> p_gain;
      end
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign phase_step_o = s_q.step;
  assign freq_word_o = s_q.freq;
  assign active_p_gain_o = p_gain;

  property p_gain_switch;
    @(posedge clk_i) disable iff (reset_i)
    sync_seen_i |-> active_p_gain_o == gain_i.timing_proportional_gain_post_sync;
  endproperty
  a_gain_switch: assert property (p_gain_switch) else $error("post-sync gain not used"); // R2

  property p_first_order_freq;
    @(posedge clk_i) disable iff (reset_i)
    (!second_order_i && !restart_i) |=> $stable(freq_word_o);
  endproperty
  a_first_order_freq: assert property (p_first_order_freq) else $error("freq moved in 1st order"); // R21

endmodule : timing_loop
`default_nettype wire

// ### rx_backend.sv
// Receive back end: timing loop, filter and IF words, RX timeout, raw data modes
//
// What this block does
// R1 - Second-order timing loop corrects frequency and phase and holds lock.
// R2 - Fast gain pair before sync detection, slow gain pair after it.
// R3 - Channel filter bandwidth chosen by mantissa 0..8 and exponent 0..9.
// R4 - Bandwidth is the table value scaled by digital clock over 26 MHz.
// R5 - IF equals reference over 12 times offset word plus 100 over 2^11.
// R6 - Timer stops on selected carrier, preamble, sync indications, AND or OR.
// R7 - No masks and select 0: timeout never expires, packet end finishes.
// R8 - No masks and select 1: timer starts at RX, cannot stop, expires.
// R9 - Single mask acts alone; sync-quality-only stop is the reset default.
// R10 - Several masks with select 0: all must be above threshold together.
// R11 - Several masks with select 1: any one above threshold stops it.
// R12 - Timeout expiry aborts reception and discards the packet.
// R13 - Host always includes sync quality in the stop condition.
// R14 - Abort command leaves RX state.
// R15 - Raw modes bypass the packet handler completely.
// R16 - Raw FIFO mode writes every received byte into the RX FIFO.
// R17 - Host drains the RX FIFO fast enough to avoid overflow.
// R18 - Raw GPIO mode drives each bit with a strobe clock on GPIO.
// R19 - GPIO data changes on the falling edge of the strobe.
// R20 - Sink samples GPIO data at the strobe falling edge.
// R21 - First-order loop uses pre/post sync proportional gain 0..7, smaller faster.
// R22 - Once stopped, timer stays halted until RX is entered again.
// R23 - Timeout expiry raises a sticky status event.
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module rx_backend
  import rx_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register bus
  input wire axil_req_s axil_req_i,
  output axil_rsp_s axil_rsp_o,
  // Demodulator side
  input wire logic carrier_sense_i,
  input wire logic preamble_quality_indication_i,
  input wire logic sync_quality_indication_i,
  input wire logic packet_done_i,
  input wire logic bit_valid_i,
  input wire logic bit_i,
  input wire logic err_valid_i,
  input wire logic signed [15:0] phase_err_i,
  // Timing loop corrections
  output logic signed [15:0] phase_step_o,
  output logic signed [15:0] freq_word_o,
  // Filter and IF words
  output logic [7:0] channel_filter_word_o,
  output logic [7:0] if_offset_analog_word_o,
  output logic [7:0] if_offset_digital_word_o,
  // Reception control
  output logic rx_active_o,
  output logic rx_discard_o,
  output logic ph_bypass_o,
  output logic ph_bit_valid_o,
  output logic ph_bit_o,
  // Raw data outputs
  output raw_out_s raw_o
);

  typedef struct packed {
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    data_mode_e mode;
    logic second_order;
    timing_gain_s gain;
    logic [3:0] filt_e;
    logic [3:0] filt_m;
    logic [7:0] if_ana;
    logic [7:0] if_dig;
    logic [2:0] stop_mask;
    logic and_or;
    logic [15:0] period;
    rx_state_e st;
    logic [15:0] timer;
    logic halted;
    logic sync_seen;
    logic tmo_flag;
    logic discard;
    logic [7:0] shift;
    logic [2:0] bitcnt;
    raw_out_s raw;
    logic pend_bit;
    logic [3:0] strobe_cnt;
  } st_s;

  st_s s_q;
  st_s s_d;
  logic [2:0] ind;
  logic stop_now;
  logic tmo_enabled;
  logic wr_fire;
  logic [31:0] wr_val;
  logic [31:0] rd_val;
  logic rd_hit;
  logic [2:0] active_p_gain;
  logic [31:0] bw_tenths;
  logic [31:0] if_freq_hz;
  logic [63:0] bw_prod;
  logic [63:0] if_prod;

  // Byte-enable merge of a write onto the current register value
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction : merge_strb

  // Stop decision; a single selected indication gives the same result either way
  function automatic logic stop_met(input logic [2:0] mask, input logic and_or,
                                    input logic [2:0] ind_v);
    logic r;
    if (mask == 3'h0) r = 1'b0;
    else if (and_or) r = |(ind_v & mask);
    else r = &(ind_v | ~mask);
    return r;
  endfunction : stop_met

  // Indication vector: bit 0 carrier, bit 1 sync quality, bit 2 preamble quality
  assign ind = {preamble_quality_indication_i, sync_quality_indication_i, carrier_sense_i};
  // R6 stop combine
  // R9 single mask
  // R10 AND of selected
  // R11 OR of selected
  assign stop_now = stop_met(s_q.stop_mask, s_q.and_or, ind);
  // R7 never expires
  // R8 unstoppable timer
  assign tmo_enabled = (s_q.stop_mask != 3'h0) || s_q.and_or;

  // R3 table lookup
  // R4 clock scaling
  always_comb begin
    bw_prod = 64'h0;
    if (s_q.filt_m <= 4'(FILT_M_MAX) && s_q.filt_e <= 4'(FILT_E_MAX)) begin
      bw_prod = (64'(CHAN_BW_TENTHS[int'(s_q.filt_m) * 10 + int'(s_q.filt_e)]) * FDIG_HZ)
                / FILTER_REF_HZ;
    end
  end
  assign bw_tenths = bw_prod[31:0];

  // R5 IF from digital offset word; out-of-range filter codes read zero
  assign if_prod = ((FDIG_HZ / IF_DIV) * (64'(s_q.if_dig) + IF_OFFSET_ADD)) >> IF_SHIFT;
  assign if_freq_hz = if_prod[31:0];

  assign wr_fire = s_q.aw_held && s_q.w_held && !s_q.bvalid;

  // Read decode, unmapped addresses answer SLVERR with zero data
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0;
    case (axil_req_i.araddr)
      OFS_CTRL: begin
        rd_val[CTRL_MODE_LSB +: 2] = s_q.mode;
        rd_val[CTRL_ALGO_BIT] = s_q.second_order;
      end
      OFS_GAIN: rd_val[11:0] = s_q.gain;
      OFS_FILT_IF: begin
        rd_val[FILT_E_LSB +: 4] = s_q.filt_e;
        rd_val[FILT_M_LSB +: 4] = s_q.filt_m;
        rd_val[IF_ANA_LSB +: 8] = s_q.if_ana;
        rd_val[IF_DIG_LSB +: 8] = s_q.if_dig;
      end
      OFS_TMO_CFG: rd_val[TMO_ANDOR_BIT:0] = {s_q.and_or, s_q.stop_mask};
      OFS_TMO_PERIOD: rd_val[15:0] = s_q.period;
      OFS_STATUS: begin
        rd_val[STAT_RX_BIT] = (s_q.st == RX_ACTIVE);
        rd_val[STAT_HALT_BIT] = s_q.halted;
        rd_val[STAT_TMO_BIT] = s_q.tmo_flag;
        rd_val[STAT_SYNC_BIT] = s_q.sync_seen;
        rd_val[STAT_PGAIN_LSB +: 3] = active_p_gain;
      end
      OFS_FILT_BW: rd_val = bw_tenths;
      OFS_IF_FREQ: rd_val = if_freq_hz;
      default: rd_hit = 1'b0;
    endcase
  end

  // Next-state logic for bus, configuration, timer and raw outputs
  always_comb begin
    s_d = s_q;
    s_d.discard = 1'b0;
    s_d.raw.fifo_push = 1'b0;
    wr_val = merge_strb(32'h0, s_q.wdata, s_q.wstrb);
    // Address and data are taken in either order and held until the write
    if (axil_req_i.awvalid && !s_q.aw_held) begin
      s_d.aw_held = 1'b1;
      s_d.awaddr = axil_req_i.awaddr;
    end
    if (axil_req_i.wvalid && !s_q.w_held) begin
      s_d.w_held = 1'b1;
      s_d.wdata = axil_req_i.wdata;
      s_d.wstrb = axil_req_i.wstrb;
    end
    if (s_q.bvalid && axil_req_i.bready) s_d.bvalid = 1'b0;
    if (s_q.rvalid && axil_req_i.rready) s_d.rvalid = 1'b0;
    if (axil_req_i.arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_val;
      s_d.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end

    // Timeout countdown; a halted timer keeps its value
    if (s_q.st == RX_ACTIVE) begin
      if (s_q.sync_seen == 1'b0 && sync_quality_indication_i) s_d.sync_seen = 1'b1;
      // R22 latch halt
      if (stop_now) s_d.halted = 1'b1;
      if (tmo_enabled && !s_q.halted && !stop_now) begin
        if (s_q.timer <= 16'h0001) begin
          // R12 abort and discard
          s_d.st = RX_IDLE;
          s_d.discard = 1'b1;
          s_d.timer = 16'h0000;
        end else begin
          s_d.timer = s_q.timer - 16'h0001;
        end
      end
      // R7 packet end
      if (packet_done_i) s_d.st = RX_IDLE;
    end

    // R15 raw byte assembly, MSB first
    if (s_q.st == RX_ACTIVE && bit_valid_i && s_q.mode == MODE_RAW_FIFO) begin
      s_d.shift = {s_q.shift[6:0], bit_i};
      s_d.bitcnt = s_q.bitcnt + 3'h1;
      // R16 push every byte
      if (s_q.bitcnt == 3'h7) begin
        s_d.raw.fifo_push = 1'b1;
        s_d.raw.fifo_data = {s_q.shift[6:0], bit_i};
      end
    end

    // R18 strobe raise
    if (s_q.st == RX_ACTIVE && bit_valid_i && s_q.mode == MODE_RAW_GPIO) begin
      s_d.pend_bit = bit_i;
      s_d.raw.gpio_clk = 1'b1;
      s_d.strobe_cnt = 4'(STROBE_HIGH_CYC);
    end else if (s_q.raw.gpio_clk) begin
      if (s_q.strobe_cnt <= 4'h1) begin
        // R19 data at falling edge
        s_d.raw.gpio_clk = 1'b0;
        s_d.raw.gpio_data = s_q.pend_bit;
      end else begin
        s_d.strobe_cnt = s_q.strobe_cnt - 4'h1;
      end
    end

    // Register writes; the start and abort bits are pulses, not stored
    if (wr_fire) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      case (s_q.awaddr)
        OFS_CTRL: begin
          if (s_q.wstrb[0]) begin
            s_d.mode = data_mode_e'(wr_val[CTRL_MODE_LSB +: 2]);
            s_d.second_order = wr_val[CTRL_ALGO_BIT];
            if (wr_val[CTRL_ABORT_BIT]) begin
              // R14 leave RX
              s_d.st = RX_IDLE;
            end else if (wr_val[CTRL_START_BIT]) begin
              // Entering RX restarts the timer and clears the halt
              s_d.st = RX_ACTIVE;
              s_d.timer = s_q.period;
              s_d.halted = 1'b0;
              s_d.sync_seen = 1'b0;
              s_d.bitcnt = 3'h0;
            end
          end
        end
        OFS_GAIN: s_d.gain = timing_gain_s'(12'(merge_strb(32'(s_q.gain), s_q.wdata,
                                                           s_q.wstrb)));
        OFS_FILT_IF: begin
          {s_d.if_dig, s_d.if_ana, s_d.filt_m, s_d.filt_e} =
            24'(merge_strb({8'h00, s_q.if_dig, s_q.if_ana, s_q.filt_m, s_q.filt_e},
                           s_q.wdata, s_q.wstrb));
        end
        OFS_TMO_CFG: if (s_q.wstrb[0]) {s_d.and_or, s_d.stop_mask} = wr_val[3:0];
        OFS_TMO_PERIOD: s_d.period = 16'(merge_strb(32'(s_q.period), s_q.wdata, s_q.wstrb));
        OFS_STATUS: if (s_q.wstrb[0] && wr_val[STAT_TMO_BIT]) s_d.tmo_flag = 1'b0;
        default: s_d.bresp = RESP_SLVERR;
      endcase
    end
    // R23 sticky event, set wins over clear
    if (s_d.discard) s_d.tmo_flag = 1'b1;
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q <= '0;
      s_q.mode <= MODE_PACKET;
      s_q.st <= RX_IDLE;
      s_q.gain <= timing_gain_s'(GAIN_RST);
      s_q.filt_e <= FILT_E_RST;
      s_q.filt_m <= FILT_M_RST;
      s_q.if_ana <= IF_ANA_RST;
      s_q.if_dig <= IF_DIG_RST;
      s_q.stop_mask <= STOP_MASK_RST;
      s_q.and_or <= TMO_ANDOR_RST;
      s_q.period <= TMO_PERIOD_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Timing loop restarts on every entry to RX
  timing_loop i_timing_loop (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .restart_i(s_q.st == RX_IDLE),
    .second_order_i(s_q.second_order),
    .sync_seen_i(s_q.sync_seen),
    .gain_i(s_q.gain),
    .err_valid_i(err_valid_i && s_q.st == RX_ACTIVE),
    .phase_err_i(phase_err_i),
    .phase_step_o(phase_step_o),
    .freq_word_o(freq_word_o),
    .active_p_gain_o(active_p_gain)
  );

  // Bus answers and output wiring; ready terms are combinational
  assign axil_rsp_o.awready = !s_q.aw_held;
  assign axil_rsp_o.wready = !s_q.w_held;
  assign axil_rsp_o.bvalid = s_q.bvalid;
  assign axil_rsp_o.bresp = s_q.bresp;
  assign axil_rsp_o.arready = !s_q.rvalid;
  assign axil_rsp_o.rvalid = s_q.rvalid;
  assign axil_rsp_o.rdata = s_q.rdata;
  assign axil_rsp_o.rresp = s_q.rresp;
  assign channel_filter_word_o = {s_q.filt_m, s_q.filt_e};
  assign if_offset_analog_word_o = s_q.if_ana;
  assign if_offset_digital_word_o = s_q.if_dig;
  assign rx_active_o = (s_q.st == RX_ACTIVE);
  assign rx_discard_o = s_q.discard;
  // R15 packet handler bypass
  assign ph_bypass_o = (s_q.mode != MODE_PACKET);
  assign ph_bit_valid_o = bit_valid_i && s_q.mode == MODE_PACKET && s_q.st == RX_ACTIVE;
  assign ph_bit_o = bit_i;
  assign raw_o = s_q.raw;

  property p_tmo_expire;
    @(posedge clk_i) disable iff (reset_i)
    (s_q.st == RX_ACTIVE && tmo_enabled && !s_q.halted && !stop_now && s_q.timer == 16'h0001
     && !packet_done_i && !wr_fire) |=> (rx_discard_o && !rx_active_o);
  endproperty
  a_tmo_expire: assert property (p_tmo_expire) else $error("timeout did not abort"); // R12

  property p_never_expire;
    @(posedge clk_i) disable iff (reset_i)
    (s_q.stop_mask == 3'h0 && !s_q.and_or) |=> !rx_discard_o;
  endproperty
  a_never_expire: assert property (p_never_expire) else $error("disabled timer expired"); // R7

  property p_halt_hold;
    @(posedge clk_i) disable iff (reset_i)
    (s_q.halted && s_q.st == RX_ACTIVE && !wr_fire) |=> $stable(s_q.timer) && !rx_discard_o;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halted timer moved"); // R22

  property p_and_stop;
    @(posedge clk_i) disable iff (reset_i)
    (s_q.st == RX_ACTIVE && !s_q.and_or && s_q.stop_mask == 3'h7 && !s_q.halted
     && !(&ind) && !wr_fire) |=> !s_q.halted;
  endproperty
  a_and_stop: assert property (p_and_stop) else $error("AND stop with missing indication"); // R10

  property p_abort;
    @(posedge clk_i) disable iff (reset_i)
    (wr_fire && s_q.awaddr == OFS_CTRL && s_q.wstrb[0] && s_q.wdata[CTRL_ABORT_BIT])
      |=> !rx_active_o;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not leave RX"); // R14

  property p_bypass;
    @(posedge clk_i) disable iff (reset_i)
    ph_bypass_o |-> !ph_bit_valid_o;
  endproperty
  a_bypass: assert property (p_bypass) else $error("raw mode fed packet handler"); // R15

  property p_gpio_fall;
    @(posedge clk_i) disable iff (reset_i)
    $changed(raw_o.gpio_data) |-> $fell(raw_o.gpio_clk);
  endproperty
  a_gpio_fall: assert property (p_gpio_fall) else $error("GPIO data moved off falling edge"); // R19

  property p_event_sticky;
    @(posedge clk_i) disable iff (reset_i)
    rx_discard_o |-> ##1 s_q.tmo_flag [*2];
  endproperty
  a_event_sticky: assert property (p_event_sticky) else $error("timeout event not held"); // R23

  property p_default_mask;
    @(posedge clk_i) reset_i |=> s_q.stop_mask == 3'h2 && !s_q.and_or;
  endproperty
  a_default_mask: assert property (p_default_mask) else $error("wrong stop default"); // R9

endmodule : rx_backend
`default_nettype wire

// ### host_sink.sv
// Host side model that drains raw FIFO pushes and GPIO bits
`timescale 1ns/1ps
`default_nettype none
module host_sink
  import rx_pkg::*;
(
  // Clock and raw data
  input wire logic clk_i,
  input wire raw_out_s raw_i,
  // Captured data
  output logic [7:0] byte_o,
  output logic [7:0] bits_o
);
  always @(posedge clk_i) if (raw_i.fifo_push) byte_o <= raw_i.fifo_data;
  always @(negedge raw_i.gpio_clk) bits_o <= {bits_o[6:0], raw_i.gpio_data};
endmodule : host_sink
`default_nettype wire

// ### test_rx_backend.sv
// Self-checking bench for the receive back end
`timescale 1ns/1ps
`default_nettype none
module test_rx_backend;
  import rx_pkg::*;
  logic clk_i = 0;
  logic reset_i = 1;
  axil_req_s req = '0;
  axil_rsp_s rsp;
  logic [2:0] ind = 3'h0;
  logic bv = 0;
  logic bt = 0;
  logic pd = 0;
  logic ev = 0;
  logic [15:0] pe = 16'h0000;
  localparam logic [7:0] RAW_PAT = 8'hA6;
  logic [15:0] ps, fw;
  logic [7:0] cfw, ana, dig, hb, hbits;
  logic act, disc, byp, pbv, pb;
  logic [1:0] resp;
  logic [31:0] v;
  raw_out_s raw;
  int err_count = 0;
  int checks = 0;
  rx_backend i_rx_backend (.clk_i(clk_i), .reset_i(reset_i), .axil_req_i(req), .axil_rsp_o(rsp),
    .carrier_sense_i(ind[0]), .preamble_quality_indication_i(ind[2]),
    .sync_quality_indication_i(ind[1]), .packet_done_i(pd), .bit_valid_i(bv), .bit_i(bt),
    .err_valid_i(ev), .phase_err_i(pe), .phase_step_o(ps), .freq_word_o(fw),
    .channel_filter_word_o(cfw), .if_offset_analog_word_o(ana), .if_offset_digital_word_o(dig),
    .rx_active_o(act), .rx_discard_o(disc), .ph_bypass_o(byp), .ph_bit_valid_o(pbv),
    .ph_bit_o(pb), .raw_o(raw));
  host_sink i_host_sink (.clk_i(clk_i), .raw_i(raw), .byte_o(hb), .bits_o(hbits));
  initial forever #2 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge clk_i);
    req <= '{awaddr: a, awvalid: 1'b1, wdata: d, wstrb: 4'hF, wvalid: 1'b1, bready: 1'b1,
      default: '0};
    while (!(aw && w)) begin
      @(posedge clk_i);
      aw = aw | rsp.awready;
      w = w | rsp.wready;
      req.awvalid <= !aw;
      req.wvalid <= !w;
    end
    while (!rsp.bvalid) @(posedge clk_i);
    req.bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    req <= '{araddr: a, arvalid: 1'b1, rready: 1'b1, default: '0};
    @(posedge clk_i);
    while (!rsp.arready) @(posedge clk_i);
    req.arvalid <= 1'b0;
    while (!rsp.rvalid) @(posedge clk_i);
    v = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd
  // Indications are dropped after entry, so a halt must be latched
  task automatic run_tmo(input logic [31:0] cfg, input logic [2:0] iv, input logic exp);
    logic seen;
    seen = 0;
    wr(OFS_TMO_CFG, cfg);
    ind <= iv;
    wr(OFS_CTRL, 32'h00000001);
    ind <= 3'h0;
    repeat (20) begin
      @(posedge clk_i);
      seen = seen | disc;
    end
    chk({31'h0, seen}, {31'h0, exp});
    wr(OFS_CTRL, 32'h00000002);
  endtask : run_tmo
  task automatic send_bit(input logic b, input int gap);
    @(posedge clk_i);
    bt <= b;
    bv <= 1'b1;
    @(posedge clk_i);
    bv <= 1'b0;
    repeat (gap) @(posedge clk_i);
  endtask : send_bit
  task automatic t_reset();
    rd(OFS_TMO_CFG);
    chk(v, 32'h00000002);
    rd(8'h20);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
  endtask : t_reset
  task automatic t_tmo();
    wr(OFS_TMO_PERIOD, 32'h00000005);
    run_tmo(32'h0, 3'h7, 1'b0);
    run_tmo(32'h8, 3'h7, 1'b1);
    run_tmo(32'h1, 3'h1, 1'b0);
    run_tmo(32'hA, 3'h1, 1'b1);
    run_tmo(32'h4, 3'h4, 1'b0);
    run_tmo(32'h3, 3'h1, 1'b1);
    run_tmo(32'h7, 3'h7, 1'b0);
    run_tmo(32'h7, 3'h3, 1'b1);
    run_tmo(32'hB, 3'h1, 1'b0);
    run_tmo(32'hE, 3'h0, 1'b1);
    rd(OFS_STATUS);
    chk(v & 32'h5, 32'h4);
  endtask : t_tmo
  // Gain pair switches when sync shows up in RX
  task automatic t_gain();
    wr(OFS_GAIN, 32'h00000143);
    wr(OFS_TMO_CFG, 32'h0);
    wr(OFS_CTRL, 32'h00000001);
    rd(OFS_STATUS);
    chk((v >> 4) & 32'h7, 32'h3);
    ind <= 3'h2;
    rd(OFS_STATUS);
    chk((v >> 4) & 32'h7, 32'h5);
    ind <= 3'h0;
  endtask : t_gain
  task automatic t_raw();
    wr(OFS_CTRL, 32'h00000005);
    for (int i = 7; i >= 0; i--) send_bit(RAW_PAT[i], 0);
    repeat (3) @(posedge clk_i);
    chk({24'h0, hb}, {24'h0, RAW_PAT});
    chk({31'h0, byp}, 32'h1);
    wr(OFS_CTRL, 32'h00000009);
    send_bit(1'b1, 14);
    send_bit(1'b0, 14);
    send_bit(1'b1, 14);
    chk({29'h0, hbits[2:0]}, 32'h5);
    wr(OFS_CTRL, 32'h00000002);
    chk({31'h0, act}, 32'h0);
  endtask : t_raw
  task automatic t_bw();
    wr(OFS_FILT_IF, 32'h00100089);
    chk({24'h0, cfw}, 32'h89);
    chk({16'h0, dig, ana}, 32'h00001000);
    rd(OFS_FILT_BW);
    chk(v, 32'h0000000B);
    rd(OFS_IF_FREQ);
    chk(v, 32'(((FDIG_HZ / IF_DIV) * (64'd16 + IF_OFFSET_ADD)) >> IF_SHIFT));
  endtask : t_bw
  // Second-order step and integrator, packet-mode bit path, packet end leaves RX
  task automatic t_loop();
    wr(OFS_CTRL, 32'h00000011);
    ev <= 1'b1;
    pe <= 16'h0040;
    bv <= 1'b1;
    bt <= 1'b1;
    @(posedge clk_i);
    chk({30'h0, pbv, pb}, 32'h3);
    ev <= 1'b0;
    bv <= 1'b0;
    @(posedge clk_i);
    chk({ps, fw}, 32'h00080040);
    pd <= 1'b1;
    @(posedge clk_i);
    pd <= 1'b0;
    @(posedge clk_i);
    chk({31'h0, act}, 32'h0);
  endtask : t_loop
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_tmo();
    t_gain();
    t_raw();
    t_bw();
    t_loop();
    report_and_stop();
  end
endmodule : test_rx_backend
`default_nettype wire
